// ### src/sfb_device.sv
`timescale 1ns/1ps
`include "sfb_defines.svh"
module sfb_device #(
  parameter int P_ERASE_PROGRAM_US = `SFB_ERASE_PROGRAM_TIME_US,
  parameter int P_PROGRAM_ONLY_US  = `SFB_PROGRAM_ONLY_TIME_US,
  parameter int P_PAGE_ERASE_US    = `SFB_PAGE_ERASE_TIME_US,
  parameter int P_BLOCK_ERASE_US   = `SFB_BLOCK_ERASE_TIME_US
) (
  sfb_link_if.dev   lnk,
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_page256,
  output logic      o_busy
);
  localparam int EP_CYC = P_ERASE_PROGRAM_US * `SFB_CLK_MHZ;
  localparam int P_CYC  = P_PROGRAM_ONLY_US * `SFB_CLK_MHZ;
  localparam int PE_CYC = P_PAGE_ERASE_US * `SFB_CLK_MHZ;
  localparam int BE_CYC = P_BLOCK_ERASE_US * `SFB_CLK_MHZ;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [8:0] sfb_last(input logic m256);
    sfb_last = m256 ? `SFB_LAST_BIN : `SFB_LAST_STD;
  endfunction : sfb_last

  function automatic logic [10:0] sfb_page_of(input logic [23:0] a,
                                              input logic        m256);
    sfb_page_of = m256 ? a[18:8] : a[19:9];
  endfunction : sfb_page_of

  function automatic logic [8:0] sfb_offset(input logic [23:0] a,
                                            input logic        m256);
    logic [8:0] o;
    o = m256 ? {1'b0, a[7:0]} : a[8:0];
    sfb_offset = (o > sfb_last(m256)) ? 9'h000 : o;
  endfunction : sfb_offset

  function automatic logic [8:0] sfb_next(input logic [8:0] p,
                                          input logic       m256);
    sfb_next = (p >= sfb_last(m256)) ? 9'h000 : p + 9'h001;
  endfunction : sfb_next

  function automatic logic [19:0] sfb_mem_idx(input logic [10:0] pg,
                                              input logic [8:0]  off);
    sfb_mem_idx = 20'(20'(pg) * `SFB_PAGE_BYTES + 20'(off));
  endfunction : sfb_mem_idx

  function automatic logic sfb_is_pe(input logic [7:0] op);
    sfb_is_pe = (op == `SFB_OP_B1_PGM_ERS) || (op == `SFB_OP_B2_PGM_ERS) ||
                (op == `SFB_OP_B1_PGM) || (op == `SFB_OP_B2_PGM) ||
                (op == `SFB_OP_PAGE_ERS) || (op == `SFB_OP_BLOCK_ERS);
  endfunction : sfb_is_pe

  function automatic logic sfb_is_bufrd(input logic [7:0] op);
    sfb_is_bufrd = (op == `SFB_OP_B1_RD_FAST) ||
                   (op == `SFB_OP_B1_RD_SLOW) ||
                   (op == `SFB_OP_B2_RD_FAST) ||
                   (op == `SFB_OP_B2_RD_SLOW);
  endfunction : sfb_is_bufrd

  function automatic logic sfb_is_wr(input logic [7:0] op);
    sfb_is_wr = (op == `SFB_OP_B1_WR) || (op == `SFB_OP_B2_WR);
  endfunction : sfb_is_wr

  function automatic logic sfb_buf_sel(input logic [7:0] op);
    sfb_buf_sel = (op == `SFB_OP_B2_RD_FAST) ||
                  (op == `SFB_OP_B2_RD_SLOW) || (op == `SFB_OP_B2_WR) ||
                  (op == `SFB_OP_B2_PGM_ERS) || (op == `SFB_OP_B2_PGM);
  endfunction : sfb_buf_sel

  function automatic logic [3:0] sfb_data_start(input logic [7:0] op);
    if (sfb_is_wr(op)) begin
      sfb_data_start = `SFB_WR_START;
    end else if (sfb_is_bufrd(op)) begin
      sfb_data_start = `SFB_BUFRD_START;
    end else if (op == `SFB_OP_PAGE_RD) begin
      sfb_data_start = `SFB_PAGERD_START;
    end else begin
      sfb_data_start = `SFB_NO_START;
    end
  endfunction : sfb_data_start

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // buffers belong to the link domain, the array to the system domain;
  // each is read across domains only while its writer is quiet
  logic [7:0]  buf_ff [0:1][0:`SFB_BUF_DEPTH-1];
  logic [7:0]  mem_ff [0:`SFB_MEM_BYTES-1];

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  logic [6:0]  sh_ff;
  logic [2:0]  bit_ff;
  logic [3:0]  byte_ff;
  logic [7:0]  opc_ff;
  logic [23:0] addr_ff;
  logic [8:0]  ptr_ff;
  logic [10:0] page_ff;
  logic [7:0]  cmd_op_ff;
  logic        req_ff;
  logic        m256_s1_ff;
  logic        m256_s2_ff;
  logic        so_ff;
  logic [7:0]  rx_byte;
  logic [23:0] full_addr;
  logic        byte_done;
  logic        reading;
  logic [7:0]  rd_byte;

  assign rx_byte   = {sh_ff, lnk.si};
  assign full_addr = {addr_ff[15:0], rx_byte};
  assign byte_done = (bit_ff == 3'h7);
  assign reading   = sfb_is_bufrd(opc_ff) || (opc_ff == `SFB_OP_PAGE_RD);

  always_ff @(posedge lnk.sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      m256_s1_ff <= 1'b0;
      m256_s2_ff <= 1'b0;
    end else begin
      m256_s1_ff <= i_page256;
      m256_s2_ff <= m256_s1_ff;
    end
  end

  // a fresh frame always starts from byte zero
  always_ff @(posedge lnk.sck or posedge lnk.csn) begin
    if (lnk.csn) begin
      sh_ff   <= 7'h00;
      bit_ff  <= 3'h0;
      byte_ff <= 4'h0;
      opc_ff  <= 8'h00;
      addr_ff <= 24'h000000;
    end else begin
      sh_ff  <= rx_byte[6:0];
      bit_ff <= bit_ff + 3'h1;
      if (byte_done && (byte_ff != 4'hf)) begin
        byte_ff <= byte_ff + 4'h1;
      end
      if (byte_done && (byte_ff == 4'h0)) begin
        opc_ff <= rx_byte;
      end
      if (byte_done && (byte_ff >= 4'h1) && (byte_ff <= 4'h3)) begin
        addr_ff <= full_addr;
      end
    end
  end

  always_ff @(posedge lnk.sck or posedge lnk.csn) begin
    if (lnk.csn) begin
      ptr_ff <= 9'h000;
    end else if (byte_done && (byte_ff == 4'h3)) begin
      ptr_ff <= sfb_offset(full_addr, m256_s2_ff);
    end else if (byte_done && (reading || sfb_is_wr(opc_ff)) &&
                 (byte_ff >= sfb_data_start(opc_ff))) begin
      ptr_ff <= sfb_next(ptr_ff, m256_s2_ff);
    end
  end

  // page and opcode stay put after the frame for the erase/program engine
  always_ff @(posedge lnk.sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      page_ff   <= 11'h000;
      cmd_op_ff <= 8'h00;
      req_ff    <= 1'b0;
    end else if (!lnk.csn && byte_done && (byte_ff == 4'h3)) begin
      page_ff <= sfb_page_of(full_addr, m256_s2_ff);
      if (sfb_is_pe(opc_ff)) begin
        cmd_op_ff <= opc_ff;
        req_ff    <= ~req_ff;
      end
    end
  end

  always_ff @(posedge lnk.sck) begin
    if (!lnk.csn && byte_done && sfb_is_wr(opc_ff) &&
        (byte_ff >= `SFB_WR_START)) begin
      buf_ff[sfb_buf_sel(opc_ff)][ptr_ff] <= rx_byte;
    end
  end

  always_comb begin
    if (sfb_is_bufrd(opc_ff)) begin
      rd_byte = buf_ff[sfb_buf_sel(opc_ff)][ptr_ff];
    end else if (opc_ff == `SFB_OP_PAGE_RD) begin
      rd_byte = mem_ff[sfb_mem_idx(page_ff, ptr_ff)];
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(negedge lnk.sck or posedge lnk.csn) begin
    if (lnk.csn) begin
      so_ff <= 1'b0;
    end else begin
      so_ff <= rd_byte[3'h7 - bit_ff];
    end
  end

  assign lnk.so    = so_ff;
  assign lnk.so_oe = !lnk.csn && reading &&
                     (byte_ff >= sfb_data_start(opc_ff));

  // ----------------------------------------
  // system domain: self-timed engine
  // ----------------------------------------
  sfb_pkg::sfb_eng_state_t st_ff;
  logic        cs_s1_ff;
  logic        cs_s2_ff;
  logic        cs_s3_ff;
  logic        rq_s1_ff;
  logic        rq_s2_ff;
  logic        ack_ff;
  logic [7:0]  op_ff;
  logic [19:0] base_ff;
  logic [11:0] idx_ff;
  logic [11:0] last_ff;
  logic [31:0] tmr_ff;
  logic        launch;
  logic [19:0] eng_addr;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_s3_ff <= 1'b1;
      rq_s1_ff <= 1'b0;
      rq_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff <= lnk.csn;
      cs_s2_ff <= cs_s1_ff;
      cs_s3_ff <= cs_s2_ff;
      rq_s1_ff <= req_ff;
      rq_s2_ff <= rq_s1_ff;
    end
  end

  // the toggle lands before the rise, so the rise decides the start
  assign launch   = cs_s2_ff && !cs_s3_ff && (rq_s2_ff != ack_ff);
  assign eng_addr = 20'(base_ff + {8'h00, idx_ff});
  assign o_busy   = (st_ff != sfb_pkg::EN_IDLE);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_ff <= 1'b0;
    end else if (launch) begin
      ack_ff <= rq_s2_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff   <= sfb_pkg::EN_IDLE;
      op_ff   <= 8'h00;
      base_ff <= 20'h00000;
      idx_ff  <= 12'h000;
      last_ff <= 12'h000;
      tmr_ff  <= 32'h0;
    end else begin
      if (tmr_ff != 32'h0) begin
        tmr_ff <= tmr_ff - 32'h1;
      end
      case (st_ff)
        sfb_pkg::EN_IDLE: begin
          // a command arriving while busy is dropped
          if (launch) begin
            op_ff  <= cmd_op_ff;
            idx_ff <= 12'h000;
            if (cmd_op_ff == `SFB_OP_BLOCK_ERS) begin
              base_ff <= sfb_mem_idx({page_ff[10:3], 3'h0}, 9'h000);
              last_ff <= `SFB_BLOCK_LAST;
              tmr_ff  <= 32'(BE_CYC);
              st_ff   <= sfb_pkg::EN_ERASE;
            end else begin
              base_ff <= sfb_mem_idx(page_ff, 9'h000);
              last_ff <= `SFB_PAGE_LAST;
              case (cmd_op_ff)
                `SFB_OP_PAGE_ERS: begin
                  tmr_ff <= 32'(PE_CYC);
                  st_ff  <= sfb_pkg::EN_ERASE;
                end
                `SFB_OP_B1_PGM, `SFB_OP_B2_PGM: begin
                  tmr_ff <= 32'(P_CYC);
                  st_ff  <= sfb_pkg::EN_PROG;
                end
                default: begin
                  tmr_ff <= 32'(EP_CYC);
                  st_ff  <= sfb_pkg::EN_ERASE;
                end
              endcase
            end
          end
        end
        sfb_pkg::EN_ERASE: begin
          idx_ff <= idx_ff + 12'h001;
          if (idx_ff == last_ff) begin
            idx_ff <= 12'h000;
            if ((op_ff == `SFB_OP_PAGE_ERS) ||
                (op_ff == `SFB_OP_BLOCK_ERS)) begin
              st_ff <= sfb_pkg::EN_WAIT;
            end else begin
              st_ff <= sfb_pkg::EN_PROG;
            end
          end
        end
        sfb_pkg::EN_PROG: begin
          idx_ff <= idx_ff + 12'h001;
          if (idx_ff == last_ff) begin
            st_ff <= sfb_pkg::EN_WAIT;
          end
        end
        sfb_pkg::EN_WAIT: begin
          if (tmr_ff == 32'h0) begin
            st_ff <= sfb_pkg::EN_IDLE;
          end
        end
        default: st_ff <= sfb_pkg::EN_IDLE;
      endcase
    end
  end

  // programming only clears bits, so an unerased page keeps its zeros
  always_ff @(posedge i_clk) begin
    if (st_ff == sfb_pkg::EN_ERASE) begin
      mem_ff[eng_addr] <= 8'hff;
    end else if (st_ff == sfb_pkg::EN_PROG) begin
      mem_ff[eng_addr] <= mem_ff[eng_addr] &
                          buf_ff[sfb_buf_sel(op_ff)][idx_ff[8:0]];
    end
  end
endmodule : sfb_device

// ### src/sfb_defines.svh
`ifndef SFB_DEFINES_SVH
`define SFB_DEFINES_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFB_OP_B1_RD_FAST 8'hd4
`define SFB_OP_B1_RD_SLOW 8'hd1
`define SFB_OP_B2_RD_FAST 8'hd6
`define SFB_OP_B2_RD_SLOW 8'hd3
`define SFB_OP_B1_WR      8'h84
`define SFB_OP_B2_WR      8'h87
`define SFB_OP_B1_PGM_ERS 8'h83
`define SFB_OP_B2_PGM_ERS 8'h86
`define SFB_OP_B1_PGM     8'h88
`define SFB_OP_B2_PGM     8'h89
`define SFB_OP_PAGE_ERS   8'h81
`define SFB_OP_BLOCK_ERS  8'h50
`define SFB_OP_PAGE_RD    8'hd2

// ----------------------------------------
// geometry and framing
// ----------------------------------------
`define SFB_PAGE_BYTES  20'h00108
`define SFB_BUF_DEPTH   264
`define SFB_MEM_BYTES   540672
`define SFB_LAST_STD    9'h107
`define SFB_LAST_BIN    9'h0ff
`define SFB_PAGE_LAST   12'h107
`define SFB_BLOCK_LAST  12'h83f
`define SFB_WR_START    4'h4
`define SFB_BUFRD_START 4'h5
`define SFB_PAGERD_START 4'h8
`define SFB_NO_START    4'hf
`define SFB_HDR_BYTES   17'h00004

// ----------------------------------------
// timing
// ----------------------------------------
`define SFB_CLK_MHZ                 25
`define SFB_ERASE_PROGRAM_TIME_US   400
`define SFB_PROGRAM_ONLY_TIME_US    300
`define SFB_PAGE_ERASE_TIME_US      200
`define SFB_BLOCK_ERASE_TIME_US     800
`define SFB_HOST_HALF_LAST          3'h3

`endif

// ### src/sfb_pkg.sv
package sfb_pkg;
  typedef enum logic [1:0] {
    EN_IDLE,
    EN_ERASE,
    EN_PROG,
    EN_WAIT
  } sfb_eng_state_t;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_LOW,
    HS_HIGH,
    HS_END,
    HS_GAP
  } sfb_host_state_t;
endpackage : sfb_pkg

// ### src/sfb_link_if.sv
`timescale 1ns/1ps
interface sfb_link_if;
  logic csn;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  wire  so_line;

  // the only place where the shared output wire is resolved; a released
  // line shows the opposite of the last bit so stale data cannot pass
  assign so_line = so_oe ? so : ~so;

  modport dev (input csn, input sck, input si, output so, output so_oe);
  modport host (output csn, output sck, output si, input so_line);
endinterface : sfb_link_if

// ### src/sfb_host.sv
`timescale 1ns/1ps
`include "sfb_defines.svh"
module sfb_host (
  sfb_link_if.host  lnk,
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [23:0] i_addr,
  input  wire logic [2:0]  i_dummy,
  input  wire logic [15:0] i_len,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_wdata,
  output logic             o_wtake,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  output logic             o_done,
  output logic             o_busy
);
  sfb_pkg::sfb_host_state_t st_ff;
  logic [2:0]  div_ff;
  logic        csn_ff;
  logic        sck_ff;
  logic [7:0]  tx_ff;
  logic [7:0]  rx_ff;
  logic [23:0] hdr_ff;
  logic [2:0]  bit_ff;
  logic [16:0] byte_ff;
  logic [16:0] last_ff;
  logic [16:0] dstart_ff;
  logic        wr_ff;
  logic        so_s1_ff;
  logic        so_s2_ff;
  logic        half;
  logic [16:0] nb;

  assign half   = (div_ff == `SFB_HOST_HALF_LAST);
  assign nb     = byte_ff + 17'h00001;
  assign o_busy = (st_ff != sfb_pkg::HS_IDLE);
  assign lnk.csn = csn_ff;
  assign lnk.sck = sck_ff;
  assign lnk.si  = tx_ff[7];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      so_s1_ff <= 1'b0;
      so_s2_ff <= 1'b0;
    end else begin
      so_s1_ff <= lnk.so_line;
      so_s2_ff <= so_s1_ff;
    end
  end

  // ----------------------------------------
  // frame sequencer, mode 0, sck = clk / 8
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff     <= sfb_pkg::HS_IDLE;
      div_ff    <= 3'h0;
      csn_ff    <= 1'b1;
      sck_ff    <= 1'b0;
      tx_ff     <= 8'h00;
      rx_ff     <= 8'h00;
      hdr_ff    <= 24'h000000;
      bit_ff    <= 3'h0;
      byte_ff   <= 17'h00000;
      last_ff   <= 17'h00000;
      dstart_ff <= 17'h00000;
      wr_ff     <= 1'b0;
      o_wtake   <= 1'b0;
      o_rdata   <= 8'h00;
      o_rvalid  <= 1'b0;
      o_done    <= 1'b0;
    end else begin
      o_wtake  <= 1'b0;
      o_rvalid <= 1'b0;
      o_done   <= 1'b0;
      div_ff   <= half ? 3'h0 : div_ff + 3'h1;
      case (st_ff)
        sfb_pkg::HS_IDLE: begin
          div_ff <= 3'h0;
          if (i_start) begin
            csn_ff    <= 1'b0;
            tx_ff     <= i_opcode;
            hdr_ff    <= i_addr;
            bit_ff    <= 3'h0;
            byte_ff   <= 17'h00000;
            wr_ff     <= i_write;
            dstart_ff <= 17'(i_dummy) + `SFB_HDR_BYTES;
            last_ff   <= 17'(i_len) + 17'(i_dummy) + 17'h00003;
            st_ff     <= sfb_pkg::HS_LOW;
          end
        end
        sfb_pkg::HS_LOW: begin
          if (half) begin
            sck_ff <= 1'b1;
            rx_ff  <= {rx_ff[6:0], so_s2_ff};
            st_ff  <= sfb_pkg::HS_HIGH;
          end
        end
        sfb_pkg::HS_HIGH: begin
          if (half) begin
            sck_ff <= 1'b0;
            st_ff  <= sfb_pkg::HS_LOW;
            if (bit_ff != 3'h7) begin
              bit_ff <= bit_ff + 3'h1;
              tx_ff  <= {tx_ff[6:0], 1'b0};
            end else begin
              if ((byte_ff >= dstart_ff) && !wr_ff) begin
                o_rdata  <= rx_ff;
                o_rvalid <= 1'b1;
              end
              bit_ff  <= 3'h0;
              byte_ff <= nb;
              if (byte_ff == last_ff) begin
                st_ff <= sfb_pkg::HS_END;
              end else if (nb < `SFB_HDR_BYTES) begin
                tx_ff  <= hdr_ff[23:16];
                hdr_ff <= {hdr_ff[15:0], 8'h00};
              end else if ((nb < dstart_ff) || !wr_ff) begin
                tx_ff <= 8'h00;
              end else begin
                tx_ff   <= i_wdata;
                o_wtake <= 1'b1;
              end
            end
          end
        end
        sfb_pkg::HS_END: begin
          if (half) begin
            csn_ff <= 1'b1;
            st_ff  <= sfb_pkg::HS_GAP;
          end
        end
        sfb_pkg::HS_GAP: begin
          // keeps chip select high long enough for the far side to see it
          if (half) begin
            o_done <= 1'b1;
            st_ff  <= sfb_pkg::HS_IDLE;
          end
        end
        default: st_ff <= sfb_pkg::HS_IDLE;
      endcase
    end
  end
endmodule : sfb_host

// ### dv/sfb_link_monitor.sv
`timescale 1ns/1ps
module sfb_link_monitor #(
  parameter int P_BUSY_MAX = 3000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic csn,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic o_busy
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic        sck_d_ff;
  logic [7:0]  rise_cnt_ff;
  logic [11:0] busy_cnt_ff;

  always_ff @(posedge i_clk) begin
    sck_d_ff <= sck;
  end

  // rising serial clock edges seen in the current frame
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || csn) begin
      rise_cnt_ff <= 8'h00;
    end else if (sck && !sck_d_ff && rise_cnt_ff != 8'hff) begin
      rise_cnt_ff <= rise_cnt_ff + 8'h01;
    end
  end

  // saturates so a stuck busy cannot wrap back under the bound
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !o_busy) begin
      busy_cnt_ff <= 12'h000;
    end else if (busy_cnt_ff != 12'hfff) begin
      busy_cnt_ff <= busy_cnt_ff + 12'h001;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_frame_end;
    !csn ##1 csn;
  endsequence

  sequence s_sck_rise;
    !sck ##1 sck;
  endsequence

  oe_needs_cs_a: assert property (so_oe |-> !csn)
    else $error("output driven while deselected");
  oe_off_end_a: assert property (s_frame_end |-> !so_oe)
    else $error("output still driven after frame end");
  sck_idle_low_a: assert property (csn && $past(csn) |-> !sck)
    else $error("serial clock not idle low");
  si_steady_a: assert property (s_sck_rise |-> $stable(si))
    else $error("input data moved at sampling edge");
  so_steady_a: assert property (s_sck_rise ##0 so_oe |-> $stable(so))
    else $error("output data moved at sampling edge");
  // the counter has not yet taken the rise that raises the enable
  data_after_hdr_a: assert property ($rose(so_oe) |->
    (rise_cnt_ff == 8'h27) || (rise_cnt_ff == 8'h3f))
    else $error("read data not right after the ignored bytes");
  busy_after_cs_a: assert property ($rose(o_busy) |-> csn && $past(csn, 2))
    else $error("busy started inside a frame");
  busy_bound_a: assert property (busy_cnt_ff < P_BUSY_MAX)
    else $error("busy never cleared");
endmodule : sfb_link_monitor

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        start = 1'b0;
  logic [7:0]  op = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [2:0]  dmy = 3'h0;
  logic [15:0] len = 16'h0000;
  logic        wr = 1'b0;
  logic        p256 = 1'b0;
  logic [7:0]  wbuf [0:3];
  int          widx = 0;
  logic [7:0]  rq [$];
  logic        wtake, rvalid, done, host_busy, dev_busy;
  logic [7:0]  rdata, wdata;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  localparam logic [7:0] a0 = 8'h3c, a1 = 8'h5a, a2 = 8'hc3, a3 = 8'h96;
  localparam logic [7:0] b0 = 8'h71, b1 = 8'he8;

  sfb_link_if lnk ();
  // short self-timed figures; the erase/program loops bound busy except program-only, whose 500-cycle timer outlasts its loop
  sfb_device #(.P_ERASE_PROGRAM_US(2), .P_PROGRAM_ONLY_US(20),
    .P_PAGE_ERASE_US(1), .P_BLOCK_ERASE_US(1)) i_sfb_device (
    .lnk(lnk.dev), .i_clk(clk), .i_sys_rst(rst), .i_page256(p256),
    .o_busy(dev_busy));
  sfb_host i_sfb_host (.lnk(lnk.host), .i_clk(clk), .i_sys_rst(rst),
    .i_start(start), .i_opcode(op), .i_addr(addr), .i_dummy(dmy),
    .i_len(len), .i_write(wr), .i_wdata(wdata), .o_wtake(wtake),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_done(done), .o_busy(host_busy));
  sfb_link_monitor #(.P_BUSY_MAX(2200)) i_sfb_link_monitor (.i_clk(clk),
    .i_sys_rst(rst), .csn(lnk.csn), .sck(lnk.sck), .si(lnk.si),
    .so(lnk.so), .so_oe(lnk.so_oe), .o_busy(dev_busy));

  always #20 clk = ~clk;
  assign wdata = wbuf[widx[1:0]];
  always @(posedge clk) if (wtake === 1'b1) widx <= widx + 1;
  always @(posedge clk) if (rvalid === 1'b1) rq.push_back(rdata);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      $display("BAD %0t run hung", $time);
      conclude();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] o, input logic [23:0] a,
                      input logic [2:0] d, input logic [15:0] n,
                      input logic w);
    rq.delete();
    widx = 0;
    @(posedge clk); #1;
    op = o; addr = a; dmy = d; len = n; wr = w; start = 1'b1;
    @(posedge clk); #1;
    start = 1'b0;
    chk({7'h00, host_busy}, 8'h01);
    do begin @(posedge clk); #1; end while (done !== 1'b1);
    chk({7'h00, host_busy}, 8'h00);
  endtask : xfer

  task automatic settle(input logic want_busy);
    int k;
    k = 0;
    while (want_busy && dev_busy !== 1'b1 && k < 16) begin
      @(posedge clk); #1; k++;
    end
    if (want_busy) chk({7'h00, dev_busy}, 8'h01);
    while (dev_busy !== 1'b0) begin @(posedge clk); #1; end
  endtask : settle

  task automatic rd_chk(input logic [7:0] o, input logic [23:0] a,
                        input logic [2:0] d, input logic [7:0] e0,
                        input logic [7:0] e1);
    xfer(o, a, d, 16'h0002, 1'b0);
    chk(rq[0], e0);
    chk(rq[1], e1);
  endtask : rd_chk

  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_buf_wrap();
    wbuf[0] = a0; wbuf[1] = a1; wbuf[2] = a2; wbuf[3] = a3;
    xfer(8'h84, 24'h000106, 3'h0, 16'h0004, 1'b1);
    rd_chk(8'hd4, 24'h000107, 3'h1, a1, a2);
    rd_chk(8'hd4, 24'hffff06, 3'h1, a0, a1);
  endtask : t_buf_wrap

  task automatic t_read_codes();
    wbuf[0] = b0; wbuf[1] = b1;
    xfer(8'h87, 24'h000000, 3'h0, 16'h0002, 1'b1);
    rd_chk(8'hd6, 24'h000000, 3'h1, b0, b1);
    rd_chk(8'hd3, 24'h000000, 3'h1, b0, b1);
    rd_chk(8'hd1, 24'h000000, 3'h1, a2, a3);
  endtask : t_read_codes

  task automatic t_program();
    xfer(8'h81, 24'h000aff, 3'h0, 16'h0000, 1'b0);
    settle(1'b1);
    rd_chk(8'hd2, 24'h000b07, 3'h4, 8'hff, 8'hff);
    xfer(8'h88, 24'h000a00, 3'h0, 16'h0000, 1'b0);
    // erase sent while still busy must be dropped
    xfer(8'h81, 24'h000a00, 3'h0, 16'h0000, 1'b0);
    chk({7'h00, dev_busy}, 8'h01);
    settle(1'b0);
    rd_chk(8'hd2, 24'h000b07, 3'h4, a1, a2);
    xfer(8'h86, 24'h000a00, 3'h0, 16'h0000, 1'b0);
    settle(1'b1);
    rd_chk(8'hd2, 24'h000a00, 3'h4, b0, b1);
  endtask : t_program

  task automatic t_block();
    xfer(8'h50, 24'h001abc, 3'h0, 16'h0000, 1'b0);
    settle(1'b1);
    rd_chk(8'hd2, 24'h000a00, 3'h4, b0, b1);
    xfer(8'h50, 24'hf00fff, 3'h0, 16'h0000, 1'b0);
    settle(1'b1);
    rd_chk(8'hd2, 24'h000a01, 3'h4, 8'hff, 8'hff);
  endtask : t_block

  task automatic t_buf_kept();
    rd_chk(8'hd4, 24'h000106, 3'h1, a0, a1);
    rd_chk(8'hd6, 24'h000000, 3'h1, b0, b1);
  endtask : t_buf_kept

  // binary page mode: 8-bit offsets, buffer wraps after byte 255
  task automatic t_bin_mode();
    p256 = 1'b1;
    wbuf[0] = b1;
    wbuf[1] = a0;
    wbuf[2] = a3;
    xfer(8'h84, 24'h0001fe, 3'h0, 16'h0003, 1'b1);
    rd_chk(8'hd4, 24'hffffff, 3'h1, a0, a3);
    rd_chk(8'hd4, 24'h0000fe, 3'h1, b1, a0);
  endtask : t_bin_mode

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_buf_wrap();
    t_read_codes();
    t_program();
    t_block();
    t_buf_kept();
    t_bin_mode();
    conclude();
  end
endmodule : tb_top
